/* File: hdl/ciq_top.sv */
`timescale 1ns/1ps
// Function
// - Normal disconnect acts after 0.5 s hold
// - Immediate mode acts on disconnect at once
// - Disconnect held 10 s opens path in hardware
// - Enable request needs 2 s hold
// - Held enable blocks shutdown input
// - Held enable blocks under-voltage turn-off
// - Shutdown request needs 0.5 s hold
// - Shutdown held 10 s forces off unless enabled
module ciq_top #(
    parameter int unsigned DISC_MIN = ciq_pkg::DISC_MIN_CYC,
    parameter int unsigned DISC_HW = ciq_pkg::DISC_HW_CYC,
    parameter int unsigned ENA_MIN = ciq_pkg::ENA_MIN_CYC,
    parameter int unsigned SHUT_MIN = ciq_pkg::SHUT_MIN_CYC,
    parameter int unsigned SHUT_HW = ciq_pkg::SHUT_HW_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic disconnect_in,
    input wire logic enable_in,
    input wire logic shutdown_in,
    input wire logic immediate_mode,
    input wire logic uvlo_fault,
    output logic disconnect_req,
    output logic hw_disconnect,
    output logic power_on_req,
    output logic shutdown_req,
    output logic hw_force_off,
    output logic uvlo_off,
    output logic enable_held
);
    import ciq_pkg::*;

    // Largest count that the shared timer width can hold, plus one
    localparam longint unsigned CNT_SPAN = 64'h1 << CNT_W;

    // Refuse disconnect timings that the timers cannot serve
    if (DISC_MIN < 1 || DISC_HW < DISC_MIN || 64'(DISC_HW) >= CNT_SPAN) begin
        $error("ciq_top: disconnect timing out of range");
    end

    // Refuse enable timing that the timer cannot serve
    if (ENA_MIN < 1 || 64'(ENA_MIN) >= CNT_SPAN) begin
        $error("ciq_top: enable timing out of range");
    end

    // Refuse shutdown timings that the timers cannot serve
    if (SHUT_MIN < 1 || SHUT_HW < SHUT_MIN || 64'(SHUT_HW) >= CNT_SPAN) begin
        $error("ciq_top: shutdown timing out of range");
    end

    // Synchronised level of the disconnect pin
    logic disc_lvl;
    // Disconnect held for the normal minimum
    logic disc_min;
    // Disconnect held for the hardware fallback time
    logic disc_long;
    // Synchronised level of the enable pin
    logic ena_lvl;
    // Enable held long enough to count as a request
    logic ena_min;
    // Synchronised level of the shutdown pin
    logic shut_lvl;
    // Shutdown held for the request minimum
    logic shut_min;
    // Shutdown held for the hardware fallback time
    logic shut_long;
    // Immediate mode strap, first and second stage
    logic mode_s1_r;
    logic mode_s2_r;
    // Under-voltage fault line, first and second stage
    logic uvlo_s1_r;
    logic uvlo_s2_r;
    // Enable already reported for this press
    logic ena_done_r;

    // Passes a request only while the enable override is released
    function automatic logic unless_enabled(input logic req, input logic ena);
        return req && !ena;
    endfunction

    // Disconnect input timer, short and long hold
    ciq_hold_timer #(
        .CNT_W(CNT_W),
        .MIN_CYC(DISC_MIN),
        .LONG_CYC(DISC_HW)
    ) u_disc (
        .clock(clock),
        .rstn(rstn),
        .pin_in(disconnect_in),
        .level(disc_lvl),
        .min_reached(disc_min),
        .long_reached(disc_long)
    );

    // Enable input timer; only the minimum hold matters
    ciq_hold_timer #(
        .CNT_W(CNT_W),
        .MIN_CYC(ENA_MIN),
        .LONG_CYC(ENA_MIN)
    ) u_ena (
        .clock(clock),
        .rstn(rstn),
        .pin_in(enable_in),
        .level(ena_lvl),
        .min_reached(ena_min),
        .long_reached()
    );

    // Shutdown input timer, short and long hold
    ciq_hold_timer #(
        .CNT_W(CNT_W),
        .MIN_CYC(SHUT_MIN),
        .LONG_CYC(SHUT_HW)
    ) u_shut (
        .clock(clock),
        .rstn(rstn),
        .pin_in(shutdown_in),
        .level(shut_lvl),
        .min_reached(shut_min),
        .long_reached(shut_long)
    );

    // Synchronise the mode strap; it may change at any time
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
        end else begin
            mode_s1_r <= immediate_mode;
            mode_s2_r <= mode_s1_r;
        end
    end

    // Synchronise the under-voltage fault line
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            uvlo_s1_r <= 1'b0;
            uvlo_s2_r <= 1'b0;
        end else begin
            uvlo_s1_r <= uvlo_fault;
            uvlo_s2_r <= uvlo_s1_r;
        end
    end

    // Disconnect request, qualified or immediate
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            disconnect_req <= FLAG_RST;
        end else if (mode_s2_r) begin
            disconnect_req <= disc_lvl;
        end else begin
            disconnect_req <= disc_min;
        end
    end

    // Hardware disconnect latches until the input releases
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hw_disconnect <= FLAG_RST;
        end else if (!disc_lvl) begin
            hw_disconnect <= 1'b0;
        end else if (disc_long) begin
            hw_disconnect <= 1'b1;
        end
    end

    // One power-on pulse per qualified enable press
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            power_on_req <= FLAG_RST;
            ena_done_r <= 1'b0;
        end else begin
            power_on_req <= ena_min && !ena_done_r;
            if (!ena_lvl) begin
                ena_done_r <= 1'b0;
            end else if (ena_min) begin
                ena_done_r <= 1'b1;
            end
        end
    end

    // Shutdown request, suppressed while enable is held
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            shutdown_req <= FLAG_RST;
        end else begin
            // Qualified shutdown, dropped while enable is held
            shutdown_req <= unless_enabled(shut_min, ena_lvl);
        end
    end

    // Hardware force-off after the long hold, unless enabled
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hw_force_off <= FLAG_RST;
        end else if (!shut_lvl || ena_lvl) begin
            hw_force_off <= 1'b0;
        end else if (shut_long) begin
            hw_force_off <= 1'b1;
        end
    end

    // Under-voltage turn-off, blocked while enable is held
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            uvlo_off <= FLAG_RST;
        end else begin
            // Fault passes only without the enable override
            uvlo_off <= unless_enabled(uvlo_s2_r, ena_lvl);
        end
    end

    // Registered view of the held enable override
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            enable_held <= FLAG_RST;
        end else begin
            // Follows the synchronised pin level
            enable_held <= ena_lvl;
        end
    end
endmodule

/* File: hdl/ciq_pkg.sv */
package ciq_pkg;
    // System clock rate in Hz
    localparam int unsigned CLK_HZ = 25000000;
    // Qualification times in milliseconds
    localparam int unsigned DISC_MIN_MS = 500;
    localparam int unsigned DISC_HW_MS = 10000;
    localparam int unsigned ENA_MIN_MS = 2000;
    localparam int unsigned SHUT_MIN_MS = 500;
    localparam int unsigned SHUT_HW_MS = 10000;
    // Least times convert to whole cycles; CLK_HZ / 1000 truncates, nothing rounds up
    localparam int unsigned DISC_MIN_CYC = (DISC_MIN_MS * (CLK_HZ / 1000) + 0) ;
    localparam int unsigned DISC_HW_CYC = DISC_HW_MS * (CLK_HZ / 1000);
    localparam int unsigned ENA_MIN_CYC = ENA_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned SHUT_MIN_CYC = SHUT_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned SHUT_HW_CYC = SHUT_HW_MS * (CLK_HZ / 1000);
    // Qualifier counter width, enough for the longest hold
    localparam int unsigned CNT_W = 28;
    // Reset value of every output flag
    localparam logic FLAG_RST = 1'b0;
endpackage

/* File: hdl/ciq_hold_timer.sv */
`timescale 1ns/1ps
// Synchronises one active-high input and reports how long it has been held
module ciq_hold_timer #(
    parameter int unsigned CNT_W = 28,
    parameter int unsigned MIN_CYC = 12500000,
    parameter int unsigned LONG_CYC = 250000000
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic pin_in,
    output logic level,
    output logic min_reached,
    output logic long_reached
);
    // Two-stage synchroniser
    logic sync1_r;
    logic sync2_r;
    // Hold counter, saturates at the long time
    logic [CNT_W-1:0] cnt_r;

    // Counter forms of the two thresholds
    localparam logic [CNT_W-1:0] MIN_V = CNT_W'(MIN_CYC);
    localparam logic [CNT_W-1:0] LONG_V = CNT_W'(LONG_CYC);

    // Refuse thresholds that the counter cannot reach
    if (MIN_CYC < 1 || LONG_CYC < MIN_CYC || 64'(LONG_CYC) >= (64'h1 << CNT_W)) begin
        $error("ciq_hold_timer: bad timing parameters");
    end

    // Synchroniser flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // Count while held, back to zero on release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (!sync2_r) begin
            cnt_r <= '0;
        end else if (cnt_r != LONG_V) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign level = sync2_r;
    assign min_reached = sync2_r && (cnt_r >= MIN_V);
    assign long_reached = sync2_r && (cnt_r == LONG_V);
endmodule

/* File: sim/ciq_switch_model.sv */
`timescale 1ns/1ps
// Momentary dry contacts on the disconnect, enable and shutdown pins
module ciq_switch_model (
    input wire logic clock,
    output logic [2:0] contact
);
    // All contacts open at power-up
    initial contact = 3'h0;
    // Closes one contact for n falling edges, then opens it
    task automatic press(input int i, input int n);
        @(negedge clock) contact[i] = 1'b1;
        repeat (n) @(negedge clock);
        contact[i] = 1'b0;
    endtask
endmodule

/* File: sim/ciq_checker.sv */
`timescale 1ns/1ps
// Ties each qualified output to how long its pin was held
module ciq_checker #(parameter int DISC_MIN = 5, DISC_HW = 20, ENA_MIN = 8, SHUT_MIN = 5, SHUT_HW = 20) (
    input logic clock,
    input logic rstn,
    input logic disconnect_in,
    input logic enable_in,
    input logic shutdown_in,
    input logic immediate_mode,
    input logic disconnect_req,
    input logic hw_disconnect,
    input logic power_on_req,
    input logic shutdown_req,
    input logic hw_force_off,
    input logic uvlo_off,
    input logic enable_held
);
    // Consecutive high samples of each pin, saturating
    logic [7:0] dc_r, ec_r, sc_r;
    function automatic logic [7:0] cnt_nxt(logic [7:0] c, logic p);
        return p ? c + 8'(c != 8'hFF) : 8'h00;
    endfunction
    // Hold counters follow the raw pins
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dc_r <= 8'h00;
            ec_r <= 8'h00;
            sc_r <= 8'h00;
        end else begin
            dc_r <= cnt_nxt(dc_r, disconnect_in);
            ec_r <= cnt_nxt(ec_r, enable_in);
            sc_r <= cnt_nxt(sc_r, shutdown_in);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    chk_disc_min: assert property ($rose(disconnect_req) && !immediate_mode |-> $past(dc_r, 4) >= DISC_MIN - 1)
        else $error("disconnect too early");
    chk_imm_cut: assert property ((immediate_mode && disconnect_in) [*5] |-> disconnect_req)
        else $error("immediate disconnect late");
    chk_hw_disc: assert property ($rose(hw_disconnect) |-> $past(dc_r, 4) >= DISC_HW - 1)
        else $error("hardware disconnect early");
    chk_power_pulse: assert property (power_on_req |-> $past(ec_r, 4) >= ENA_MIN - 1 ##1 !power_on_req)
        else $error("bad power on pulse");
    chk_shut_min: assert property ($rose(shutdown_req) |-> $past(sc_r, 4) >= SHUT_MIN - 1)
        else $error("shutdown too early");
    chk_hw_off: assert property ($rose(hw_force_off) |-> $past(sc_r, 4) >= SHUT_HW - 1)
        else $error("forced off early");
    chk_enable_block: assert property (enable_held [*2] |-> !shutdown_req && !hw_force_off && !uvlo_off)
        else $error("enable did not block");
    chk_disc_release: assert property (!disconnect_in [*6] |-> !disconnect_req && !hw_disconnect)
        else $error("disconnect stuck");
    cover property ($rose(hw_disconnect));
    cover property (power_on_req);
    cover property ($rose(hw_force_off));
endmodule
bind ciq_top ciq_checker #(.DISC_MIN(DISC_MIN), .DISC_HW(DISC_HW), .ENA_MIN(ENA_MIN), .SHUT_MIN(SHUT_MIN),
    .SHUT_HW(SHUT_HW)) u_chk (.clock(clock), .rstn(rstn), .disconnect_in(disconnect_in), .enable_in(enable_in),
    .shutdown_in(shutdown_in), .immediate_mode(immediate_mode), .disconnect_req(disconnect_req),
    .hw_disconnect(hw_disconnect), .power_on_req(power_on_req), .shutdown_req(shutdown_req),
    .hw_force_off(hw_force_off), .uvlo_off(uvlo_off), .enable_held(enable_held));

/* File: sim/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED %0t value mismatch", $time); end end
// Presses the pins and compares the qualified outputs
module tb;
    logic clock = 1'b0, rstn = 1'b0, imm = 1'b0, uvlo = 1'b0, seen, seen_off;
    logic [2:0] pin;
    logic [6:0] q;
    int n_fail = 0, total_checks = 0;
    // Row: pin, watched output, mode, hold cycles, expected
    typedef struct {int p; int o; logic m; int h; logic e;} ciq_row_type;
    ciq_row_type rows[11] = '{'{0, 0, 0, 3, 0}, '{0, 0, 0, 12, 1}, '{0, 0, 1, 2, 1}, '{0, 1, 0, 18, 0},
        '{0, 1, 0, 24, 1}, '{1, 2, 0, 6, 0}, '{1, 2, 0, 14, 1}, '{2, 3, 0, 3, 0}, '{2, 3, 0, 12, 1},
        '{2, 4, 0, 18, 0}, '{2, 4, 0, 24, 1}};
    ciq_switch_model sw (.clock(clock), .contact(pin));
    ciq_top #(.DISC_MIN(5), .DISC_HW(20), .ENA_MIN(8), .SHUT_MIN(5), .SHUT_HW(20)) uut (.clock(clock), .rstn(rstn),
        .disconnect_in(pin[0]), .enable_in(pin[1]), .shutdown_in(pin[2]), .immediate_mode(imm), .uvlo_fault(uvlo),
        .disconnect_req(q[0]), .hw_disconnect(q[1]), .power_on_req(q[2]), .shutdown_req(q[3]),
        .hw_force_off(q[4]), .uvlo_off(q[5]), .enable_held(q[6]));
    // Presses one pin and records whether the output ever rose
    task automatic run(input int p, input int o, input int h, output logic s);
        s = 1'b0;
        fork
            sw.press(p, h);
            repeat (h + 8) @(posedge clock) #1 s |= q[o];
        join
    endtask
    // Prints the counts and the verdict
    task automatic results;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Free-running 25 MHz clock
    initial forever #20 clock = ~clock;
    // Watchdog well past the expected run
    initial begin
        #40000;
        n_fail++;
        results();
    end
    // Table rows, then enable override and reset
    initial begin
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        foreach (rows[i]) begin
            @(negedge clock) imm = rows[i].m;
            run(rows[i].p, rows[i].o, rows[i].h, seen);
            `CHK(seen, rows[i].e)
            `CHK(q[rows[i].o], 1'b0)
            $display("row %0d done", i);
        end
        // Two short pulses with a gap must not add up
        fork
            begin
                sw.press(0, 3);
                repeat (2) @(negedge clock);
                sw.press(0, 3);
            end
            begin
                seen = 1'b0;
                repeat (16) @(posedge clock) #1 seen |= q[0];
            end
        join
        `CHK(seen, 1'b0)
        $display("glitch restart done");
        @(negedge clock) uvlo = 1'b1;
        fork
            sw.press(1, 50);
            begin
                repeat (6) @(posedge clock);
                seen_off = 1'b0;
                fork
                    run(2, 3, 26, seen);
                    repeat (34) @(posedge clock) #1 seen_off |= q[4];
                join
                `CHK(seen, 1'b0)
                `CHK(seen_off, 1'b0)
                `CHK(q[5], 1'b0)
                `CHK(q[6], 1'b1)
            end
        join
        repeat (8) @(negedge clock);
        `CHK(q[5], 1'b1)
        rstn = 1'b0;
        #1 `CHK(q[5], 1'b0)
        $display("override and reset done");
        results();
    end
endmodule
